// >>> core/pcsp_pkg.sv
// package: register map, field layout and divisor decode for the clock prescaler
package pcsp_pkg;

  localparam int ADDR_W = 12;
  localparam logic [11:0] OFS_BUS_CLOCK_CONTROL = 12'h02c;
  localparam logic [11:0] OFS_UART_CLOCK_SOURCE_SELECT = 12'h030;
  localparam logic [11:0] OFS_PERIPH_CLOCK_SOURCE_SELECT = 12'h034;
  localparam logic [11:0] OFS_SILICON_REVISION = 12'h03c;
  localparam logic [11:0] OFS_LCD_CLOCK_DIVIDER = 12'h040;
  localparam logic [11:0] OFS_SYNC_SERIAL_CLOCK_DIVIDER = 12'h044;
  localparam logic [11:0] OFS_CONVERTER_CLOCK_DIVIDER = 12'h048;
  localparam logic [11:0] OFS_USB_CLOCK_DIVIDER = 12'h04c;
  localparam logic [11:0] OFS_CLOCK_STATUS = 12'h050;

  // field positions
  localparam int BIT_DMA_GATE = 0;
  localparam int BIT_SEL_SYNC_SERIAL = 1;
  localparam int BIT_SEL_CONVERTER = 2;
  localparam int BIT_SEL_USB = 3;
  localparam int STAT_PENDING_LSB = 8;
  localparam int NUM_UART = 3;
  localparam int DIV_W = 8;

  // reset values
  localparam logic [2:0] RST_UART_SEL = 3'h0;
  localparam logic [2:0] RST_PERIPH_SEL = 3'h0;
  localparam logic [7:0] RST_DIVISOR = 8'h00;
  localparam logic RST_DMA_GATE = 1'b0;

  // per-peripheral one-cycle clock enables
  typedef struct packed {
    logic [2:0] uart;
    logic syncSerial;
    logic converter;
    logic usbDevice;
    logic lcdData;
  } pcsp_ticks_t;

  // terminal count for a divisor field: zero passes through, bit k gives 2^(k+1)-1;
  // an illegal pattern falls back to its highest set bit
  function automatic logic [7:0] div_limit(input logic [7:0] div);
    logic [8:0] tmp;
    logic [7:0] lim;
    tmp = 9'h000;
    lim = 8'h00;
    for (int i = 0; i < 8; i++) begin
      if (div[i]) begin
        tmp = (9'h002 << i) - 9'h001;
        lim = tmp[7:0];
      end
    end
    return lim;
  endfunction : div_limit

endpackage : pcsp_pkg

// >>> core/pcsp_divider.sv
// glitch-free source select and power-of-two divider producing a clock enable
`timescale 1ns/10ps
`default_nettype none
module pcsp_divider (
  input wire logic clk, // bus clock
  input wire logic rst, // synchronous reset, active high
  input wire logic srcTickLow, // source enable chosen when select is 0
  input wire logic srcTickHigh, // source enable chosen when select is 1
  input wire logic selReq, // requested source select
  input wire logic [7:0] divReq, // requested divisor field
  output logic tickOut, // one-cycle divided clock enable
  output logic selActive, // source select now in use
  output logic pending // request not yet applied
);

  logic sel_q;
  logic [7:0] lim_q;
  logic [7:0] cnt_q;
  logic tick_q;
  logic srcTick;
  logic atWrap;
  logic [7:0] limReq;

  assign srcTick = sel_q ? srcTickHigh : srcTickLow;
  assign atWrap = srcTick && (cnt_q == lim_q);
  assign limReq = pcsp_pkg::div_limit(divReq);

  always_ff @(posedge clk) begin
    if (rst) begin
      sel_q <= 1'b0;
      lim_q <= 8'h00;
    end else if (atWrap) begin
      sel_q <= selReq;
      lim_q <= limReq;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      cnt_q <= 8'h00;
    end else if (atWrap) begin
      cnt_q <= 8'h00;
    end else if (srcTick) begin
      cnt_q <= cnt_q + 8'h01;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      tick_q <= 1'b0;
    end else begin
      tick_q <= atWrap;
    end
  end

  assign tickOut = tick_q;
  assign selActive = sel_q;
  assign pending = (sel_q != selReq) || (lim_q != limReq);

endmodule : pcsp_divider
`default_nettype wire

// >>> core/pcsp_top.sv
// peripheral clock source select and prescaler block with APB register slave
`timescale 1ns/10ps
`default_nettype none
// Functional notes
// - uart select bit: 1 bus clock, 0 crystal
// - usb select: 1 usb pll, 0 bus; resets 0
// - converter select: 1 oscillator, 0 bus clock
// - sync serial select: 1 oscillator, 0 bus
// - reserved bits read zero; software writes zero
// - lcd clock: bus clock divided by 2^(k+1)
// - sync serial clock divided likewise, up to 256
// - converter clock divided likewise, up to 256
// - usb clock divided likewise, up to 256
// - usb divisor resets to zero, divide by one
// - read-only 16-bit revision in low half
// - dma bus clock gated when bit is 1
module pcsp_top #(
  parameter logic [15:0] REVISION_NUMBER = 16'h00a5 // arbitrary value
) (
  input wire logic sys_clk, // bus clock, 40 MHz
  input wire logic rst, // synchronous reset, active high
  input wire logic psel, // apb select
  input wire logic penable, // apb access phase
  input wire logic pwrite, // apb direction
  input wire logic [11:0] paddr, // apb byte address
  input wire logic [31:0] pwdata, // apb write data
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // apb error on unmapped address
  input wire logic xtalClkIn, // crystal oscillator clock, asynchronous
  input wire logic usbPllClkIn, // usb pll clock, asynchronous
  output pcsp_pkg::pcsp_ticks_t clkTicks, // per-peripheral clock enables
  output logic dmaBusClkEn // dma controller bus clock enable
);

  localparam logic [31:0] ZERO32 = 32'h0000_0000;

  logic [2:0] uartSel_q;
  logic [2:0] periphSel_q;
  logic [7:0] lcd_data_clock_divisor_q;
  logic [7:0] ssDiv_q;
  logic [7:0] convDiv_q;
  logic [7:0] usb_divisor_q;
  logic dmaGate_q;
  logic [31:0] prdata_q;
  logic [2:0] xtalSync_q;
  logic [2:0] pllSync_q;
  logic xtalTick;
  logic pllTick;
  logic busTick;
  logic addrHit;
  logic wrEn;
  logic [31:0] rdMux;
  logic [2:0] uartTick;
  logic [2:0] uartActive;
  logic [2:0] uartPend;
  logic [3:0] perTick;
  logic [3:0] perActive;
  logic [3:0] perPend;

  assign busTick = 1'b1;

  // two-stage synchronisers, edge found on the settled stages only
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      xtalSync_q <= 3'h0;
      pllSync_q <= 3'h0;
    end else begin
      xtalSync_q <= {xtalSync_q[1:0], xtalClkIn};
      pllSync_q <= {pllSync_q[1:0], usbPllClkIn};
    end
  end

  assign xtalTick = xtalSync_q[1] && !xtalSync_q[2];
  assign pllTick = pllSync_q[1] && !pllSync_q[2];

  // apb decode
  always_comb begin
    unique case (paddr)
      pcsp_pkg::OFS_BUS_CLOCK_CONTROL,
      pcsp_pkg::OFS_UART_CLOCK_SOURCE_SELECT,
      pcsp_pkg::OFS_PERIPH_CLOCK_SOURCE_SELECT,
      pcsp_pkg::OFS_SILICON_REVISION,
      pcsp_pkg::OFS_LCD_CLOCK_DIVIDER,
      pcsp_pkg::OFS_SYNC_SERIAL_CLOCK_DIVIDER,
      pcsp_pkg::OFS_CONVERTER_CLOCK_DIVIDER,
      pcsp_pkg::OFS_USB_CLOCK_DIVIDER,
      pcsp_pkg::OFS_CLOCK_STATUS: addrHit = 1'b1;
      default: addrHit = 1'b0;
    endcase
  end

  assign wrEn = psel && penable && pwrite && addrHit;

  always_comb begin
    rdMux = ZERO32;
    unique case (paddr)
      pcsp_pkg::OFS_BUS_CLOCK_CONTROL: rdMux[pcsp_pkg::BIT_DMA_GATE] = dmaGate_q;
      pcsp_pkg::OFS_UART_CLOCK_SOURCE_SELECT: rdMux[2:0] = uartSel_q;
      pcsp_pkg::OFS_PERIPH_CLOCK_SOURCE_SELECT: rdMux[3:1] = periphSel_q;
      pcsp_pkg::OFS_SILICON_REVISION: rdMux[15:0] = REVISION_NUMBER;
      pcsp_pkg::OFS_LCD_CLOCK_DIVIDER: rdMux[7:0] = lcd_data_clock_divisor_q;
      pcsp_pkg::OFS_SYNC_SERIAL_CLOCK_DIVIDER: rdMux[7:0] = ssDiv_q;
      pcsp_pkg::OFS_CONVERTER_CLOCK_DIVIDER: rdMux[7:0] = convDiv_q;
      pcsp_pkg::OFS_USB_CLOCK_DIVIDER: rdMux[7:0] = usb_divisor_q;
      pcsp_pkg::OFS_CLOCK_STATUS: begin
        rdMux[2:0] = uartActive;
        rdMux[6:3] = perActive;
        rdMux[pcsp_pkg::STAT_PENDING_LSB +: 7] = {perPend, uartPend};
      end
      default: rdMux = ZERO32;
    endcase
  end

  // read data captured in the setup phase, stable through the access phase
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      prdata_q <= ZERO32;
    end else if (psel && !penable) begin
      prdata_q <= pwrite ? ZERO32 : rdMux;
    end
  end

  assign prdata = prdata_q;
  assign pready = 1'b1;
  assign pslverr = psel && penable && !addrHit;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      uartSel_q <= pcsp_pkg::RST_UART_SEL;
    end else if (wrEn && paddr == pcsp_pkg::OFS_UART_CLOCK_SOURCE_SELECT) begin
      uartSel_q <= pwdata[2:0];
    end
  end

  // usb, converter, sync serial selects reset to bus clock
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      periphSel_q <= pcsp_pkg::RST_PERIPH_SEL;
    end else if (wrEn && paddr == pcsp_pkg::OFS_PERIPH_CLOCK_SOURCE_SELECT) begin
      periphSel_q <= pwdata[3:1];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      lcd_data_clock_divisor_q <= pcsp_pkg::RST_DIVISOR;
      ssDiv_q <= pcsp_pkg::RST_DIVISOR;
      convDiv_q <= pcsp_pkg::RST_DIVISOR;
      usb_divisor_q <= pcsp_pkg::RST_DIVISOR;
    end else if (wrEn) begin
      if (paddr == pcsp_pkg::OFS_LCD_CLOCK_DIVIDER) begin
        lcd_data_clock_divisor_q <= pwdata[7:0];
      end
      if (paddr == pcsp_pkg::OFS_SYNC_SERIAL_CLOCK_DIVIDER) begin
        ssDiv_q <= pwdata[7:0];
      end
      if (paddr == pcsp_pkg::OFS_CONVERTER_CLOCK_DIVIDER) begin
        convDiv_q <= pwdata[7:0];
      end
      if (paddr == pcsp_pkg::OFS_USB_CLOCK_DIVIDER) begin
        usb_divisor_q <= pwdata[7:0];
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      dmaGate_q <= pcsp_pkg::RST_DMA_GATE;
    end else if (wrEn && paddr == pcsp_pkg::OFS_BUS_CLOCK_CONTROL) begin
      dmaGate_q <= pwdata[pcsp_pkg::BIT_DMA_GATE];
    end
  end

  assign dmaBusClkEn = !dmaGate_q;

  // uart: select 1 bus clock, 0 crystal, no divisor
  for (genvar g = 0; g < pcsp_pkg::NUM_UART; g++) begin : gUart
    pcsp_divider uDiv (
      .clk(sys_clk),
      .rst(rst),
      .srcTickLow(xtalTick),
      .srcTickHigh(busTick),
      .selReq(uartSel_q[g]),
      .divReq(pcsp_pkg::RST_DIVISOR),
      .tickOut(uartTick[g]),
      .selActive(uartActive[g]),
      .pending(uartPend[g])
    );
  end

  // lcd data clock from bus clock only
  pcsp_divider uLcd (
    .clk(sys_clk),
    .rst(rst),
    .srcTickLow(busTick),
    .srcTickHigh(busTick),
    .selReq(1'b0),
    .divReq(lcd_data_clock_divisor_q),
    .tickOut(perTick[0]),
    .selActive(perActive[0]),
    .pending(perPend[0])
  );

  // sync serial: 1 oscillator, 0 bus clock
  pcsp_divider uSyncSerial (
    .clk(sys_clk),
    .rst(rst),
    .srcTickLow(busTick),
    .srcTickHigh(xtalTick),
    .selReq(periphSel_q[0]),
    .divReq(ssDiv_q),
    .tickOut(perTick[1]),
    .selActive(perActive[1]),
    .pending(perPend[1])
  );

  // converter: 1 oscillator, 0 bus clock
  pcsp_divider uConverter (
    .clk(sys_clk),
    .rst(rst),
    .srcTickLow(busTick),
    .srcTickHigh(xtalTick),
    .selReq(periphSel_q[1]),
    .divReq(convDiv_q),
    .tickOut(perTick[2]),
    .selActive(perActive[2]),
    .pending(perPend[2])
  );

  // usb: 1 usb pll, 0 bus clock
  pcsp_divider uUsb (
    .clk(sys_clk),
    .rst(rst),
    .srcTickLow(busTick),
    .srcTickHigh(pllTick),
    .selReq(periphSel_q[2]),
    .divReq(usb_divisor_q),
    .tickOut(perTick[3]),
    .selActive(perActive[3]),
    .pending(perPend[3])
  );

  assign clkTicks.uart = uartTick;
  assign clkTicks.lcdData = perTick[0];
  assign clkTicks.syncSerial = perTick[1];
  assign clkTicks.converter = perTick[2];
  assign clkTicks.usbDevice = perTick[3];

endmodule : pcsp_top
`default_nettype wire

// >>> testbench/pcsp_top_sva.sv
// assertion checker for the clock prescaler register slave
`timescale 1ns/10ps
`default_nettype none
module pcsp_top_chk #(
  parameter logic [15:0] REVISION_NUMBER = 16'h00a5 // arbitrary value
) (
  input wire logic sys_clk, // bus clock
  input wire logic rst, // sync reset
  input wire logic psel, // select
  input wire logic penable, // access
  input wire logic pwrite, // direction
  input wire logic [11:0] paddr, // address
  input wire logic [31:0] pwdata, // write data
  input wire logic [31:0] prdata, // read data
  input wire logic pready, // ready
  input wire logic pslverr, // error
  input wire logic dmaBusClkEn // dma clock enable
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  logic acc;
  logic rdAcc;
  logic mapped;
  assign acc = psel && penable;
  assign rdAcc = acc && !pwrite;
  assign mapped = paddr inside {12'h02c, 12'h030, 12'h034, 12'h03c, 12'h040, 12'h044,
    12'h048, 12'h04c, 12'h050};
  ready_const_a: assert property (pready) else $error("ready low");
  err_unmapped_a: assert property (acc && !mapped |-> pslverr)
    else $error("no error on unmapped address");
  err_quiet_a: assert property (pslverr |-> acc && !mapped) else $error("spurious error");
  dma_cause_a: assert property ($changed(dmaBusClkEn) |-> $past(acc && pwrite && paddr == 12'h02c))
    else $error("dma enable moved without a write");
  dma_value_a: assert property (acc && pwrite && paddr == 12'h02c |=> dmaBusClkEn != $past(pwdata[0]))
    else $error("dma enable wrong after write");
  rev_read_a: assert property (rdAcc && paddr == 12'h03c |-> prdata == {16'h0000, REVISION_NUMBER})
    else $error("revision read wrong");
  sel_resv_a: assert property (rdAcc && paddr == 12'h034 |-> prdata[31:4] == 28'h0 && !prdata[0])
    else $error("select reserved bits set");
  uart_resv_a: assert property (rdAcc && paddr == 12'h030 |-> prdata[31:3] == 29'h0)
    else $error("uart select reserved bits set");
  div_resv_a: assert property (rdAcc && paddr inside {12'h040, 12'h044, 12'h048, 12'h04c}
    |-> prdata[31:8] == 24'h0) else $error("divisor reserved bits set");
  cover property (acc && !mapped);
  cover property ($fell(dmaBusClkEn));
  cover property (rdAcc && paddr == 12'h03c);
endmodule : pcsp_top_chk
bind pcsp_top pcsp_top_chk #(.REVISION_NUMBER(REVISION_NUMBER)) chk_u (.sys_clk(sys_clk),
  .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .dmaBusClkEn(dmaBusClkEn));
`default_nettype wire

// >>> testbench/test_pcsp_top.sv
// self-checking bench for the clock prescaler block
`timescale 1ns/10ps
`default_nettype none
`define CHK(got, exp) begin samples_checked++; if ((got) !== (exp)) begin err_count++; \
  $display("Error %0t: mismatch got %0h exp %0h", $time, got, exp); end end
module test_pcsp_top;
  localparam logic [15:0] REV = 16'h00a5;
  localparam logic [11:0] OFFS [6] = '{12'h030, 12'h034, 12'h040, 12'h044, 12'h048, 12'h04c};
  logic sys_clk, rst, psel, penable, pwrite, xtalClkIn, usbPllClkIn;
  logic pready, pslverr, dmaBusClkEn, errSeen;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rdData;
  pcsp_pkg::pcsp_ticks_t clkTicks;
  int err_count, samples_checked;
  pcsp_top #(.REVISION_NUMBER(REV)) dut_u (.sys_clk(sys_clk), .rst(rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .xtalClkIn(xtalClkIn), .usbPllClkIn(usbPllClkIn),
    .clkTicks(clkTicks), .dmaBusClkEn(dmaBusClkEn));
  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end
  // crystal runs at a tenth, usb pll at a sixth of the bus clock
  initial begin
    xtalClkIn = 1'b0;
    forever begin
      repeat (5) @(posedge sys_clk);
      xtalClkIn <= ~xtalClkIn;
    end
  end
  initial begin
    usbPllClkIn = 1'b0;
    forever begin
      repeat (3) @(posedge sys_clk);
      usbPllClkIn <= ~usbPllClkIn;
    end
  end
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    // pready is looked at on each access edge, and the answer is taken at the same edge
    do begin
      @(posedge sys_clk);
      n++;
    end while (pready !== 1'b1 && n < 100);
    if (pready !== 1'b1) begin
      err_count++;
      $display("Error %0t: no ready from slave", $time);
    end
    rdData = prdata;
    errSeen = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge sys_clk);
  endtask : apb
  task automatic rd(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    `CHK(rdData, exp)
  endtask : rd
  // spacing of the fourth tick after a change, once the new setting holds
  task automatic measure(input int b, input int exp);
    int c;
    repeat (4) begin
      c = 0;
      do begin
        @(negedge sys_clk);
        c++;
      end while (clkTicks[b] !== 1'b1 && c < 3000);
    end
    `CHK(c, exp)
  endtask : measure
  task automatic finish_test;
    $display("checks %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : finish_test
  initial begin
    repeat (40000) @(posedge sys_clk);
    err_count++;
    $display("Error %0t: watchdog expired", $time);
    finish_test();
  end
  initial begin
    rst = 1'b1;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    err_count = 0;
    samples_checked = 0;
    repeat (10) @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
    foreach (OFFS[i]) rd(OFFS[i], 32'h0);
    rd(12'h03c, {16'h0000, REV});
    `CHK(dmaBusClkEn, 1'b1)
    $display("test reset_values done");
    apb(1'b1, 12'h030, '1);
    rd(12'h030, 32'h7);
    apb(1'b1, 12'h034, '1);
    rd(12'h034, 32'he);
    apb(1'b1, 12'h03c, '1);
    rd(12'h03c, {16'h0000, REV});
    apb(1'b1, 12'h040, '1);
    rd(12'h040, 32'hff);
    rd(12'h0f0, 32'h0);
    `CHK(errSeen, 1'b1)
    foreach (OFFS[i]) apb(1'b1, OFFS[i], 32'h0);
    $display("test register_access done");
    for (int k = 0; k < 8; k++) begin
      apb(1'b1, 12'h040, 32'h1 << k);
      measure(0, 2 ** (k + 1));
    end
    apb(1'b1, 12'h040, 32'h0);
    measure(0, 1);
    apb(1'b1, 12'h044, 32'h04);
    measure(3, 8);
    apb(1'b1, 12'h048, 32'h80);
    measure(2, 256);
    apb(1'b1, 12'h04c, 32'h02);
    measure(1, 4);
    apb(1'b1, 12'h04c, 32'h01);
    measure(1, 2);
    $display("test bus_divide done");
    apb(1'b1, 12'h048, 32'h0);
    apb(1'b1, 12'h034, 32'he);
    measure(3, 80);
    measure(2, 10);
    measure(1, 12);
    for (int b = 4; b < 7; b++) measure(b, 10);
    apb(1'b1, 12'h030, 32'h7);
    for (int b = 4; b < 7; b++) measure(b, 1);
    // status: every select applied, lcd stays on the bus clock, nothing pending
    rd(12'h050, 32'h77);
    $display("test source_select done");
    apb(1'b1, 12'h02c, 32'h1);
    `CHK(dmaBusClkEn, 1'b0)
    rd(12'h02c, 32'h1);
    apb(1'b1, 12'h02c, 32'h0);
    `CHK(dmaBusClkEn, 1'b1)
    $display("test dma_gate done");
    finish_test();
  end
endmodule : test_pcsp_top
`default_nettype wire
